// ---- core/oag_page_add.sv ----
/*
 Direct-page adder: forms page:(base+index) with wrap inside the page.
 Assumes a page byte from the core.
*/
`timescale 1ns/10ps
module oag_page_add (
   input  wire logic [7:0]  i_page,
   input  wire logic [7:0]  i_base,
   input  wire logic [7:0]  i_index,
   output logic      [15:0] o_addr
);
   logic [7:0] sum;
   // Carry out is dropped on purpose so the page never changes
   assign sum    = 8'(i_base + i_index);
   assign o_addr = {i_page, sum};
endmodule

// ---- core/oag_pkg.sv ----
/*
 Package for the operand address generator: addressing mode codes,
 operand source codes and sequencing constants.
 Assumes nothing of its surroundings.
*/
package oag_pkg;
   typedef enum logic [3:0] {
      OAG_MODE_REG,
      OAG_MODE_IMM,
      OAG_MODE_DP,
      OAG_MODE_ABS,
      OAG_MODE_DPX,
      OAG_MODE_DPX_INC,
      OAG_MODE_DPX_OFS,
      OAG_MODE_DPY_OFS,
      OAG_MODE_ABS_Y,
      OAG_MODE_IND_DP,
      OAG_MODE_IND_DPX,
      OAG_MODE_IND_DPY,
      OAG_MODE_IND_ABS
   } oag_mode_t;

   typedef enum logic [2:0] {
      OAG_SRC_ACC,
      OAG_SRC_X,
      OAG_SRC_Y,
      OAG_SRC_CARRY,
      OAG_SRC_FLAGS
   } oag_src_t;

   localparam int         OAG_ADDR_W   = 16;
   localparam int         OAG_DATA_W   = 8;
   localparam logic [7:0] OAG_INC_STEP = 8'h01;
   localparam logic [7:0] OAG_ZERO_8   = 8'h00;
   localparam logic [0:0] OAG_PTR_LOW  = 1'h0;
   localparam logic [0:0] OAG_PTR_HIGH = 1'h1;
endpackage

// ---- core/oag_ptr_fetch.sv ----
/*
 Pointer fetch sequencer: reads a low then a high byte of a 16-bit pointer.
 Assumes memory answers i_rd_valid one or more cycles after o_rd_req.
*/
`timescale 1ns/10ps
module oag_ptr_fetch (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [15:0] i_addr_lo,
   input  wire logic [15:0] i_addr_hi,
   input  wire logic [7:0]  i_rd_data,
   input  wire logic        i_rd_valid,
   output logic             o_rd_req,
   output logic      [15:0] o_rd_addr,
   output logic             o_done,
   output logic      [15:0] o_ptr
);
   typedef enum {OAG_PF_IDLE, OAG_PF_LOW, OAG_PF_HIGH} oag_pf_t;
   oag_pf_t     state, next_state;
   logic [7:0]  low, next_low;
   logic [15:0] hi_addr, next_hi_addr, next_rd_addr, next_ptr;
   logic        next_rd_req, next_done;

   always_comb begin
      next_state   = state;
      next_low     = low;
      next_hi_addr = hi_addr;
      next_rd_addr = o_rd_addr;
      next_rd_req  = 1'b0;
      next_done    = 1'b0;
      next_ptr     = o_ptr;
      case (state)
         OAG_PF_IDLE: begin
            if (i_start) begin
               next_hi_addr = i_addr_hi;
               next_rd_addr = i_addr_lo;
               next_rd_req  = 1'b1;
               next_state   = OAG_PF_LOW;
            end
         end
         OAG_PF_LOW: begin
            if (i_rd_valid) begin
               next_low     = i_rd_data;
               next_rd_addr = hi_addr;
               next_rd_req  = 1'b1;
               next_state   = OAG_PF_HIGH;
            end
         end
         OAG_PF_HIGH: begin
            if (i_rd_valid) begin
               next_ptr   = {i_rd_data, low};
               next_done  = 1'b1;
               next_state = OAG_PF_IDLE;
            end
         end
         default: next_state = OAG_PF_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state     <= OAG_PF_IDLE;
         low       <= 8'h00;
         hi_addr   <= 16'h0000;
         o_rd_addr <= 16'h0000;
         o_rd_req  <= 1'b0;
         o_done    <= 1'b0;
         o_ptr     <= 16'h0000;
      end else begin
         state     <= next_state;
         low       <= next_low;
         hi_addr   <= next_hi_addr;
         o_rd_addr <= next_rd_addr;
         o_rd_req  <= next_rd_req;
         o_done    <= next_done;
         o_ptr     <= next_ptr;
      end
   end
endmodule

// ---- core/oag_top.sv ----
/*
 Operand address generator top: turns an addressing mode, operand bytes
 and the index registers into an effective address or operand value.
 Assumes the core holds i_start for one cycle and waits for o_done.
*/
// Operation
// - Register mode takes operand from A, X, Y, carry or flags, no memory.
// - Immediate mode uses the byte after the opcode as the value.
// - Direct page mode: address is page byte and operand byte.
// - Absolute mode: second byte low, third byte high, whole space.
// - X indexed without offset: X is the location in the page.
// - Auto increment: access page location X, then X plus one.
// - X with offset: operand plus X, stays in the page.
// - Y with offset: operand plus Y, stays in the page.
// - Y indexed absolute: 16-bit address plus Y, anywhere.
// - Page indirect jump: pointer pair at operand is the target.
// - X indexed indirect: pointer at operand plus X, then access it.
// - Y post-indexed: pointer at operand, plus Y gives address.
// - Absolute indirect jump: pointer at absolute address loads PC.
`timescale 1ns/10ps
module oag_top (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   input  wire logic                   i_start,
   input  wire oag_pkg::oag_mode_t     i_mode,
   input  wire oag_pkg::oag_src_t      i_src,
   input  wire logic [7:0]             i_op1,
   input  wire logic [7:0]             i_op2,
   input  wire logic [7:0]             i_page,
   input  wire logic [7:0]             i_acc,
   input  wire logic [7:0]             i_x,
   input  wire logic [7:0]             i_y,
   input  wire logic                   i_carry,
   input  wire logic [7:0]             i_flags,
   input  wire logic [7:0]             i_rd_data,
   input  wire logic                   i_rd_valid,
   output logic                        o_rd_req,
   output logic      [15:0]            o_rd_addr,
   output logic                        o_done,
   output logic      [15:0]            o_ea,
   output logic                        o_ea_valid,
   output logic      [7:0]             o_value,
   output logic                        o_value_valid,
   output logic                        o_pc_load,
   output logic      [7:0]             o_x_new,
   output logic                        o_x_write
);
   typedef enum {OAG_ST_IDLE, OAG_ST_PTR} oag_st_t;

   oag_st_t            state, next_state;
   oag_pkg::oag_mode_t mode, next_mode;
   logic [7:0]         y_hold, next_y_hold;
   logic [15:0]        next_ea;
   logic [7:0]         next_value, next_x_new;
   logic               next_done, next_ea_valid, next_value_valid;
   logic               next_pc_load, next_x_write;
   logic [15:0]        dp_plain, dp_x, dp_y, dp_xp1, dp_op1, dp_op1p1;
   logic [15:0]        abs_addr, abs_p1, abs_y;
   logic               pf_start;
   logic [15:0]        pf_lo, pf_hi, pf_ptr, pf_rd_addr;
   logic               pf_done, pf_rd_req;
   logic [7:0]         x_plus_op;

   assign abs_addr  = {i_op2, i_op1};
   assign abs_p1    = 16'(abs_addr + 16'h0001);
   assign abs_y     = 16'(abs_addr + {8'h00, i_y});
   assign x_plus_op = 8'(i_op1 + i_x);

   oag_page_add u_dp_plain (.i_page(i_page), .i_base(i_op1), .i_index(oag_pkg::OAG_ZERO_8),
                            .o_addr(dp_plain));
   oag_page_add u_dp_x     (.i_page(i_page), .i_base(i_op1), .i_index(i_x),
                            .o_addr(dp_x));
   oag_page_add u_dp_y     (.i_page(i_page), .i_base(i_op1), .i_index(i_y),
                            .o_addr(dp_y));
   oag_page_add u_dp_xp1   (.i_page(i_page), .i_base(x_plus_op),
                            .i_index(oag_pkg::OAG_INC_STEP), .o_addr(dp_xp1));
   oag_page_add u_dp_op1   (.i_page(i_page), .i_base(oag_pkg::OAG_ZERO_8), .i_index(i_x),
                            .o_addr(dp_op1));
   oag_page_add u_dp_op1p1 (.i_page(i_page), .i_base(i_op1),
                            .i_index(oag_pkg::OAG_INC_STEP), .o_addr(dp_op1p1));

   // Pointer source addresses for the indirect modes
   always_comb begin
      pf_lo = dp_plain;
      pf_hi = dp_op1p1;
      case (i_mode)
         oag_pkg::OAG_MODE_IND_DPX: begin
            pf_lo = dp_x;
            pf_hi = dp_xp1;
         end
         oag_pkg::OAG_MODE_IND_ABS: begin
            pf_lo = abs_addr;
            pf_hi = abs_p1;
         end
         default: begin
            pf_lo = dp_plain;
            pf_hi = dp_op1p1;
         end
      endcase
   end

   oag_ptr_fetch u_fetch (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_start   (pf_start),
      .i_addr_lo (pf_lo),
      .i_addr_hi (pf_hi),
      .i_rd_data (i_rd_data),
      .i_rd_valid(i_rd_valid),
      .o_rd_req  (pf_rd_req),
      .o_rd_addr (pf_rd_addr),
      .o_done    (pf_done),
      .o_ptr     (pf_ptr)
   );

   always_comb begin
      next_state       = state;
      next_mode        = mode;
      next_y_hold      = y_hold;
      next_ea          = o_ea;
      next_value       = o_value;
      next_x_new       = o_x_new;
      next_done        = 1'b0;
      next_ea_valid    = 1'b0;
      next_value_valid = 1'b0;
      next_pc_load     = 1'b0;
      next_x_write     = 1'b0;
      pf_start         = 1'b0;
      case (state)
         OAG_ST_IDLE: begin
            if (i_start) begin
               next_mode   = i_mode;
               next_y_hold = i_y;
               next_done   = 1'b1;
               case (i_mode)
                  oag_pkg::OAG_MODE_REG: begin
                     next_value_valid = 1'b1;
                     case (i_src)
                        oag_pkg::OAG_SRC_X:     next_value = i_x;
                        oag_pkg::OAG_SRC_Y:     next_value = i_y;
                        oag_pkg::OAG_SRC_CARRY: next_value = {7'h00, i_carry};
                        oag_pkg::OAG_SRC_FLAGS: next_value = i_flags;
                        default:                next_value = i_acc;
                     endcase
                  end
                  oag_pkg::OAG_MODE_IMM: begin
                     next_value       = i_op1;
                     next_value_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_DP: begin
                     next_ea       = dp_plain;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_ABS: begin
                     next_ea       = abs_addr;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_DPX: begin
                     next_ea       = dp_op1;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_DPX_INC: begin
                     next_ea       = dp_op1;
                     next_ea_valid = 1'b1;
                     next_x_new    = 8'(i_x + oag_pkg::OAG_INC_STEP);
                     next_x_write  = 1'b1;
                  end
                  oag_pkg::OAG_MODE_DPX_OFS: begin
                     next_ea       = dp_x;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_DPY_OFS: begin
                     next_ea       = dp_y;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_ABS_Y: begin
                     next_ea       = abs_y;
                     next_ea_valid = 1'b1;
                  end
                  oag_pkg::OAG_MODE_IND_DP,
                  oag_pkg::OAG_MODE_IND_DPX,
                  oag_pkg::OAG_MODE_IND_DPY,
                  oag_pkg::OAG_MODE_IND_ABS: begin
                     next_done  = 1'b0;
                     pf_start   = 1'b1;
                     next_state = OAG_ST_PTR;
                  end
                  default: begin
                     next_ea       = dp_plain;
                     next_ea_valid = 1'b1;
                  end
               endcase
            end
         end
         OAG_ST_PTR: begin
            if (pf_done) begin
               next_done     = 1'b1;
               next_state    = OAG_ST_IDLE;
               next_ea_valid = 1'b1;
               case (mode)
                  oag_pkg::OAG_MODE_IND_DPY:
                     next_ea = 16'(pf_ptr + {8'h00, y_hold});
                  oag_pkg::OAG_MODE_IND_DP,
                  oag_pkg::OAG_MODE_IND_ABS: begin
                     next_ea      = pf_ptr;
                     next_pc_load = 1'b1;
                  end
                  default: next_ea = pf_ptr;
               endcase
            end
         end
         default: next_state = OAG_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state         <= OAG_ST_IDLE;
         mode          <= oag_pkg::OAG_MODE_REG;
         y_hold        <= 8'h00;
         o_ea          <= 16'h0000;
         o_value       <= 8'h00;
         o_x_new       <= 8'h00;
         o_done        <= 1'b0;
         o_ea_valid    <= 1'b0;
         o_value_valid <= 1'b0;
         o_pc_load     <= 1'b0;
         o_x_write     <= 1'b0;
         o_rd_req      <= 1'b0;
         o_rd_addr     <= 16'h0000;
      end else begin
         state         <= next_state;
         mode          <= next_mode;
         y_hold        <= next_y_hold;
         o_ea          <= next_ea;
         o_value       <= next_value;
         o_x_new       <= next_x_new;
         o_done        <= next_done;
         o_ea_valid    <= next_ea_valid;
         o_value_valid <= next_value_valid;
         o_pc_load     <= next_pc_load;
         o_x_write     <= next_x_write;
         o_rd_req      <= pf_rd_req;
         o_rd_addr     <= pf_rd_addr;
      end
   end

   a_imm_value: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_IMM)
      |=> (o_value == $past(i_op1) && o_value_valid && !o_ea_valid))
      else $error("immediate value wrong");
   a_reg_no_mem: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_REG)
      |=> (o_value_valid && o_done) ##1 !o_rd_req)
      else $error("register mode touched memory");
   a_dp_addr: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_DP)
      |=> (o_ea == {$past(i_page), $past(i_op1)}))
      else $error("direct page address wrong");
   a_abs_addr: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_ABS)
      |=> (o_ea == {$past(i_op2), $past(i_op1)}))
      else $error("absolute address wrong");
   a_dpx_plain: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_DPX)
      |=> (o_ea == {$past(i_page), $past(i_x)}))
      else $error("x page address wrong");
   a_x_incr: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_DPX_INC)
      |=> (o_x_write && o_x_new == 8'($past(i_x) + 8'h01) && o_ea[7:0] == $past(i_x)))
      else $error("auto increment wrong");
   a_dpx_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_DPX_OFS)
      |=> (o_ea[15:8] == $past(i_page) && o_ea[7:0] == 8'($past(i_op1) + $past(i_x))))
      else $error("x offset address left page");
   a_dpy_wrap: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_DPY_OFS)
      |=> (o_ea[15:8] == $past(i_page) && o_ea[7:0] == 8'($past(i_op1) + $past(i_y))))
      else $error("y offset address left page");
   a_ptr_pair: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_rd_req && state == OAG_ST_PTR) |-> ##[1:1000] (pf_done || o_rd_req))
      else $error("pointer fetch stalled");
   a_jump_load: assert property (@(posedge i_clock) disable iff (i_rst)
      o_pc_load |-> (o_done && o_ea_valid && (mode == oag_pkg::OAG_MODE_IND_ABS
      || mode == oag_pkg::OAG_MODE_IND_DP)))
      else $error("pc load in wrong mode");
   a_abs_y_addr: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == OAG_ST_IDLE && i_start && i_mode == oag_pkg::OAG_MODE_ABS_Y)
      |=> (o_ea == 16'({$past(i_op2), $past(i_op1)} + {8'h00, $past(i_y)})))
      else $error("y absolute address wrong");
   a_x_write_mode: assert property (@(posedge i_clock) disable iff (i_rst)
      o_x_write |-> (o_done && o_ea_valid && mode == oag_pkg::OAG_MODE_DPX_INC))
      else $error("x written outside auto increment");

   c_imm: cover property (@(posedge i_clock) o_value_valid);
   c_ind_abs: cover property (@(posedge i_clock) o_pc_load && mode == oag_pkg::OAG_MODE_IND_ABS);
   c_ind_y: cover property (@(posedge i_clock) o_done && mode == oag_pkg::OAG_MODE_IND_DPY);
   c_x_incr: cover property (@(posedge i_clock) o_x_write);
endmodule

// ---- verif/oag_mem_model.sv ----
/*
 Behavioural program and data memory answering pointer byte reads.
 Assumes one o_rd_req pulse per byte and a clock from the bench.
*/
`timescale 1ns/10ps
module oag_mem_model (
   input  wire logic        i_clock,
   input  wire logic        i_rd_req,
   input  wire logic [15:0] i_rd_addr,
   input  wire logic [3:0]  i_delay,
   output logic      [7:0]  o_rd_data,
   output logic             o_rd_valid
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr;
   logic        busy;
   int          wait_n;

   initial begin
      o_rd_valid = 1'b0;
      o_rd_data  = 8'hA5;
      busy       = 1'b0;
      wait_n     = 0;
   end

   // Answers on the falling edge; data churns while not valid
   always @(negedge i_clock) begin : answer
      logic       nv;
      logic [7:0] nd;
      nv = 1'b0;
      nd = ~o_rd_data;
      if (i_rd_req === 1'b1 && !busy) begin
         busy   = 1'b1;
         addr   = i_rd_addr;
         wait_n = i_delay;
      end
      if (busy) begin
         if (wait_n == 0) begin
            nv   = 1'b1;
            nd   = mem[addr];
            busy = 1'b0;
         end else begin
            wait_n = wait_n - 1;
         end
      end
      o_rd_valid <= nv;
      o_rd_data  <= nd;
   end
endmodule

// ---- verif/oag_top_tb.sv ----
/*
 Self-checking bench for the operand address generator top.
 Assumes the memory model beside it answers every pointer read.
*/
`timescale 1ns/10ps
module oag_top_tb;
   logic                i_clock = 1'b0;
   logic                i_rst   = 1'b1;
   logic                i_start = 1'b0;
   oag_pkg::oag_mode_t  i_mode  = oag_pkg::OAG_MODE_REG;
   oag_pkg::oag_src_t   i_src   = oag_pkg::OAG_SRC_ACC;
   logic [7:0]          i_op1   = 8'h00;
   logic [7:0]          i_op2   = 8'h00;
   logic [7:0]          i_page  = 8'h01;
   logic [7:0]          i_acc   = 8'hAA;
   logic [7:0]          i_x     = 8'h15;
   logic [7:0]          i_y     = 8'h55;
   logic                i_carry = 1'b1;
   logic [7:0]          i_flags = 8'hC3;
   logic [3:0]          delay   = 4'h0;
   logic [7:0]          i_rd_data;
   logic                i_rd_valid;
   logic                o_rd_req, o_done, o_ea_valid, o_value_valid, o_pc_load, o_x_write;
   logic [15:0]         o_rd_addr, o_ea;
   logic [7:0]          o_value, o_x_new;
   int                  fails = 0;
   int                  n_compared = 0;
   int                  cycles = 0;
   int                  n_rd;

   oag_top oag_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_start(i_start),
      .i_mode(i_mode), .i_src(i_src), .i_op1(i_op1), .i_op2(i_op2), .i_page(i_page),
      .i_acc(i_acc), .i_x(i_x), .i_y(i_y), .i_carry(i_carry), .i_flags(i_flags),
      .i_rd_data(i_rd_data), .i_rd_valid(i_rd_valid), .o_rd_req(o_rd_req),
      .o_rd_addr(o_rd_addr), .o_done(o_done), .o_ea(o_ea), .o_ea_valid(o_ea_valid),
      .o_value(o_value), .o_value_valid(o_value_valid), .o_pc_load(o_pc_load),
      .o_x_new(o_x_new), .o_x_write(o_x_write));

   oag_mem_model oag_mem_model_inst (.i_clock(i_clock), .i_rd_req(o_rd_req),
      .i_rd_addr(o_rd_addr), .i_delay(delay), .o_rd_data(i_rd_data),
      .o_rd_valid(i_rd_valid));

   initial begin
      forever #25 i_clock = ~i_clock;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard well above the fewer than one hundred cycles the tests need
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end

   // Entered at a falling edge; pulses are sampled at falling edges
   task automatic run(input oag_pkg::oag_mode_t m, input logic [7:0] a, input logic [7:0] b,
                      input logic [15:0] lo, input logic [15:0] hi);
      int k;
      i_mode  = m;
      i_op1   = a;
      i_op2   = b;
      i_start = 1'b1;
      n_rd    = 0;
      for (k = 0; k < 40; k++) begin
         @(negedge i_clock);
         i_start = 1'b0;
         if (o_rd_req === 1'b1) begin
            check(o_rd_addr, (n_rd == 0) ? lo : hi);
            n_rd++;
         end
         if (o_done === 1'b1) begin
            break;
         end
      end
      check({15'h0, o_done}, 16'h0001);
   endtask

   task automatic t_register();
      logic [7:0] exp [5];
      exp = '{8'hAA, 8'h15, 8'h55, 8'h01, 8'hC3};
      for (int i = 0; i < 5; i++) begin
         i_src = oag_pkg::oag_src_t'(i);
         run(oag_pkg::OAG_MODE_REG, 8'h00, 8'h00, 16'h0, 16'h0);
         check({8'h0, o_value}, {8'h0, exp[i]});
         check({14'h0, o_value_valid, o_ea_valid}, 16'h0002);
         check(16'(n_rd), 16'h0000);
      end
      run(oag_pkg::OAG_MODE_IMM, 8'h35, 8'h00, 16'h0, 16'h0);
      check({8'h0, o_value}, 16'h0035);
      check({14'h0, o_value_valid, o_ea_valid}, 16'h0002);
      $display("test register and immediate done");
   endtask

   task automatic t_direct();
      run(oag_pkg::OAG_MODE_DP, 8'hFF, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h01FF);
      check({15'h0, o_ea_valid}, 16'h0001);
      run(oag_pkg::OAG_MODE_ABS, 8'h35, 8'hF0, 16'h0, 16'h0);
      check(o_ea, 16'hF035);
      check(16'(n_rd), 16'h0000);
      $display("test direct and absolute done");
   endtask

   task automatic t_indexed();
      i_x = 8'h15;
      run(oag_pkg::OAG_MODE_DPX, 8'h77, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h0115);
      i_x = 8'hFF;
      run(oag_pkg::OAG_MODE_DPX_INC, 8'h00, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h01FF);
      check({7'h0, o_x_write, o_x_new}, 16'h0100);
      i_x = 8'h20;
      run(oag_pkg::OAG_MODE_DPX_OFS, 8'hF0, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h0110);
      i_y = 8'hA1;
      run(oag_pkg::OAG_MODE_DPY_OFS, 8'h70, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h0111);
      i_y = 8'h55;
      run(oag_pkg::OAG_MODE_ABS_Y, 8'h00, 8'hFA, 16'h0, 16'h0);
      check(o_ea, 16'hFA55);
      run(oag_pkg::OAG_MODE_ABS_Y, 8'hF0, 8'h12, 16'h0, 16'h0);
      check(o_ea, 16'h1345);
      $display("test indexed done");
   endtask

   task automatic t_indirect();
      oag_mem_model_inst.mem[16'h0135] = 8'h0A;
      oag_mem_model_inst.mem[16'h0136] = 8'hF3;
      oag_mem_model_inst.mem[16'h01FF] = 8'h34;
      oag_mem_model_inst.mem[16'h0100] = 8'h12;
      oag_mem_model_inst.mem[16'hF025] = 8'hCD;
      oag_mem_model_inst.mem[16'hF026] = 8'hAB;
      run(oag_pkg::OAG_MODE_IND_DP, 8'h35, 8'h00, 16'h0135, 16'h0136);
      check(o_ea, 16'hF30A);
      check({15'h0, o_pc_load}, 16'h0001);
      i_x   = 8'h0F;
      delay = 4'h3;
      run(oag_pkg::OAG_MODE_IND_DPX, 8'hF0, 8'h00, 16'h01FF, 16'h0100);
      check(o_ea, 16'h1234);
      check({15'h0, o_pc_load}, 16'h0000);
      check(16'(n_rd), 16'h0002);
      i_y = 8'h10;
      run(oag_pkg::OAG_MODE_IND_DPY, 8'h35, 8'h00, 16'h0135, 16'h0136);
      check(o_ea, 16'hF31A);
      check({15'h0, o_pc_load}, 16'h0000);
      delay = 4'h0;
      run(oag_pkg::OAG_MODE_IND_ABS, 8'h25, 8'hF0, 16'hF025, 16'hF026);
      check(o_ea, 16'hABCD);
      check({15'h0, o_pc_load}, 16'h0001);
      $display("test indirect done");
   endtask

   task automatic t_reset();
      i_mode  = oag_pkg::OAG_MODE_IND_ABS;
      i_start = 1'b1;
      @(negedge i_clock);
      i_start = 1'b0;
      i_rst   = 1'b1;
      repeat (2) @(negedge i_clock);
      i_rst = 1'b0;
      check({o_rd_req, o_done, o_ea_valid, o_pc_load, 12'h0}, 16'h0000);
      check(o_ea, 16'h0000);
      run(oag_pkg::OAG_MODE_DP, 8'h42, 8'h00, 16'h0, 16'h0);
      check(o_ea, 16'h0142);
      $display("test reset mid operation done");
   endtask

   initial begin
      repeat (2) @(negedge i_clock);
      i_rst = 1'b0;
      t_register();
      t_direct();
      t_indexed();
      t_indirect();
      t_reset();
      stop_test();
   end
endmodule
